/* File: tmt_consts.vh */
// Purpose: constants for the third timer control block
// Assumes: 8-bit register port, 20 MHz ref_clk_i
// Notes: definitions only
`ifndef TMT_CONSTS_VH
`define TMT_CONSTS_VH
`define TMT_ADDR_W 8
`define TMT_ADDR_CTRL 8'hC8
`define TMT_ADDR_CAPL 8'hCA
`define TMT_ADDR_CAPH 8'hCB
`define TMT_ADDR_CNTL 8'hCC
`define TMT_ADDR_CNTH 8'hCD
`define TMT_ADDR_MODE 8'hC9
`define TMT_ADDR_ISTAT 8'hCE
`define TMT_ADDR_IMASK 8'hCF
`define TMT_CTRL_RST 8'h00
`define TMT_BIT_OVF 7
`define TMT_BIT_EXF 6
`define TMT_BIT_RXB 5
`define TMT_BIT_TXB 4
`define TMT_BIT_EXEN 3
`define TMT_BIT_RUN 2
`define TMT_BIT_CNT 1
`define TMT_BIT_CAP 0
`define TMT_BIT_UDEN 0
`define TMT_IRQ_OVF 0
`define TMT_IRQ_EXF 1
`define TMT_CNT_MAX 16'hFFFF
`endif

/* File: tmt_fall_det.v */
// Purpose: falling edge detector for one pin
// Assumes: pin synchronous to the clock
// Notes: one-cycle pulse
`timescale 1ns/1ps
module tmt_fall_det (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire pin_i,
   output wire fall_o
);
   reg prev_q;
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         prev_q <= 1'b1;
      end else begin
         prev_q <= pin_i;
      end
   end
   assign fall_o = prev_q & ~pin_i;
endmodule // tmt_fall_det

/* File: tmt_cap_reg.v */
// Purpose: 16-bit capture/reload register pair
// Assumes: byte writes from software, capture from hardware
// Notes: capture wins over software write
`timescale 1ns/1ps
module tmt_cap_reg (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire wr_low_i,
   input wire wr_high_i,
   input wire [7:0] wdata_i,
   input wire capture_i,
   input wire [15:0] count_i,
   output wire [15:0] value_o
);
   reg [15:0] val_q;
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         val_q <= 16'h0000;
      end else if (capture_i) begin
         val_q <= count_i;
      end else if (wr_low_i) begin
         val_q[7:0] <= wdata_i;
      end else if (wr_high_i) begin
         val_q[15:8] <= wdata_i;
      end
   end
   assign value_o = val_q;
endmodule // tmt_cap_reg

/* File: tmt_timer.v */
// Behaviour
// RQ1: overflow sets flag, software only clears it
// RQ2: no overflow flag while baud source set
// RQ3: trigger capture/reload sets external event flag
// RQ4: event flag requests irq unless updown on
// RQ5: receive baud from our overflow when selected
// RQ6: transmit baud from our overflow when selected
// RQ7: trigger edge acts only when enabled, no baud
// RQ8: counts only while run bit set
// RQ9: timer or external falling-edge counter select
// RQ10: capture count on trigger edge in capture mode
// RQ11: reload on overflow and enabled trigger edge
// RQ12: baud use forces auto-reload on overflow
// RQ13: high/low capture reload byte pair
// RQ14: control at 0C8H, reset zero, bit writable
// RQ15: unlisted bits read zero, future bits inactive
// RQ16: count pin events, trigger pin direction control
// RQ17: capture copies count, reload loads same cycle
//
// Purpose: control, count and status of the third timer/counter
// Assumes: byte register port, read data one cycle after read strobe
// Notes: irq status cleared by writing ones
`timescale 1ns/1ps
`include "tmt_consts.vh"
module tmt_timer (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire bit_wr_i,
   input wire [2:0] bit_sel_i,
   input wire bit_val_i,
   output reg [7:0] rdata_o,
   input wire count_pin_i,
   input wire trigger_pin_i,
   input wire t1_ovf_i,
   output reg rx_baud_tick_o,
   output reg tx_baud_tick_o,
   output reg timer_irq_req_o,
   output wire irq_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // registers
   reg [7:0] ctrl_q;
   reg [7:0] ctrl_d;
   reg uden_q;
   reg [15:0] cnt_q;
   reg [15:0] cnt_d;
   reg [1:0] istat_q;
   reg [1:0] istat_d;
   reg [1:0] imask_q;
   wire [15:0] cap_val;
   wire cnt_fall;
   wire trg_fall;
   wire wr_ctrl;
   wire wr_capl;
   wire wr_caph;
   wire baud;
   wire tick;
   wire ovf;
   wire trg_act;
   wire cap_ev;
   wire reload;
   wire up_dir;
   wire underflow;

   tmt_fall_det u_cnt_det (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(count_pin_i),
      .fall_o(cnt_fall)
   );

   tmt_fall_det u_trg_det (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(trigger_pin_i),
      .fall_o(trg_fall)
   );

   assign wr_ctrl = wr_i & (addr_i == `TMT_ADDR_CTRL);
   assign wr_capl = wr_i & (addr_i == `TMT_ADDR_CAPL);
   assign wr_caph = wr_i & (addr_i == `TMT_ADDR_CAPH);

   ////////////////////////////////////////////////////////////////////////////////
   // count control
   assign baud = ctrl_q[`TMT_BIT_RXB] | ctrl_q[`TMT_BIT_TXB];
   // timer clocked every cycle, counter by pin edges
   assign tick = ctrl_q[`TMT_BIT_RUN] &
      (ctrl_q[`TMT_BIT_CNT] ? cnt_fall : 1'b1); // RQ8 RQ9 RQ16
   // up/down mode: trigger pin level sets direction
   assign up_dir = ~uden_q | baud | trigger_pin_i; // RQ16
   assign ovf = tick & up_dir & (cnt_q == `TMT_CNT_MAX);
   assign underflow = tick & ~up_dir & (cnt_q == cap_val);
   assign trg_act = trg_fall & ctrl_q[`TMT_BIT_EXEN] & ~baud & ~uden_q; // RQ7
   assign cap_ev = trg_act & ctrl_q[`TMT_BIT_CAP]; // RQ10
   assign reload = (ovf & (~ctrl_q[`TMT_BIT_CAP] | baud)) |
      (trg_act & ~ctrl_q[`TMT_BIT_CAP]); // RQ11 RQ12

   tmt_cap_reg u_cap (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_low_i(wr_capl),
      .wr_high_i(wr_caph),
      .wdata_i(wdata_i),
      .capture_i(cap_ev), // RQ13 RQ17
      .count_i(cnt_q),
      .value_o(cap_val)
   );

   always @* begin
      cnt_d = cnt_q;
      if (reload) begin
         cnt_d = cap_val; // RQ17
      end else if (underflow) begin
         cnt_d = `TMT_CNT_MAX;
      end else if (tick) begin
         cnt_d = up_dir ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
      end
      if (wr_i && addr_i == `TMT_ADDR_CNTL) begin
         cnt_d[7:0] = wdata_i;
      end
      if (wr_i && addr_i == `TMT_ADDR_CNTH) begin
         cnt_d[15:8] = wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register and flags
   always @* begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wdata_i;
      end else if (bit_wr_i) begin
         ctrl_d[bit_sel_i] = bit_val_i; // RQ14
      end
      // hardware set wins over software clear
      if ((ovf | underflow) & ~baud) begin
         ctrl_d[`TMT_BIT_OVF] = 1'b1; // RQ1 RQ2
      end
      if (cap_ev | (trg_act & ~ctrl_q[`TMT_BIT_CAP])) begin
         ctrl_d[`TMT_BIT_EXF] = 1'b1; // RQ3
      end
   end

   always @* begin
      istat_d = istat_q;
      if (wr_i && addr_i == `TMT_ADDR_ISTAT) begin
         istat_d = istat_q & ~wdata_i[1:0];
      end
      if ((ovf | underflow) & ~baud) begin
         istat_d[`TMT_IRQ_OVF] = 1'b1;
      end
      if (trg_act) begin
         istat_d[`TMT_IRQ_EXF] = 1'b1;
      end
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl_q <= `TMT_CTRL_RST; // RQ14
         uden_q <= 1'b0;
         cnt_q <= 16'h0000;
         istat_q <= 2'b00;
         imask_q <= 2'b00;
      end else begin
         ctrl_q <= ctrl_d;
         cnt_q <= cnt_d;
         istat_q <= istat_d;
         if (wr_i && addr_i == `TMT_ADDR_MODE) begin
            uden_q <= wdata_i[`TMT_BIT_UDEN];
         end
         if (wr_i && addr_i == `TMT_ADDR_IMASK) begin
            imask_q <= wdata_i[1:0];
         end
      end
   end

   assign irq_o = |(istat_q & imask_q);

   ////////////////////////////////////////////////////////////////////////////////
   // baud ticks and timer request
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rx_baud_tick_o <= 1'b0;
         tx_baud_tick_o <= 1'b0;
         timer_irq_req_o <= 1'b0;
      end else begin
         rx_baud_tick_o <= ctrl_q[`TMT_BIT_RXB] ? ovf : t1_ovf_i; // RQ5
         tx_baud_tick_o <= ctrl_q[`TMT_BIT_TXB] ? ovf : t1_ovf_i; // RQ6
         timer_irq_req_o <= ctrl_d[`TMT_BIT_OVF] |
            (ctrl_d[`TMT_BIT_EXF] & ~uden_q); // RQ4
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read port
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            `TMT_ADDR_CTRL: rdata_o <= ctrl_q;
            `TMT_ADDR_MODE: rdata_o <= {7'h00, uden_q}; // RQ15
            `TMT_ADDR_CAPL: rdata_o <= cap_val[7:0];
            `TMT_ADDR_CAPH: rdata_o <= cap_val[15:8];
            `TMT_ADDR_CNTL: rdata_o <= cnt_q[7:0];
            `TMT_ADDR_CNTH: rdata_o <= cnt_q[15:8];
            `TMT_ADDR_ISTAT: rdata_o <= {6'h00, istat_q};
            `TMT_ADDR_IMASK: rdata_o <= {6'h00, imask_q};
            default: rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule // tmt_timer

/* File: tmt_timer_assertions.sv */
// Purpose: port checks of tmt_timer
// Assumes: shadow of software control bits
// Notes: bound below
`timescale 1ns/1ps
`include "tmt_consts.vh"
module tmt_timer_chk (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire bit_wr_i,
   input wire [2:0] bit_sel_i,
   input wire bit_val_i,
   input wire [7:0] rdata_o,
   input wire t1_ovf_i,
   input wire rx_baud_tick_o,
   input wire tx_baud_tick_o,
   input wire timer_irq_req_o
);
   reg [5:0] sh_q;
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) sh_q <= 6'h00;
      else if (wr_i && addr_i == 8'hC8) sh_q <= wdata_i[5:0];
      else if (bit_wr_i && bit_sel_i < 3'h6) sh_q[bit_sel_i] <= bit_val_i;
   end
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence ctrl_rd;
      rd_i && addr_i == 8'hC8 ##1 1'b1;
   endsequence
   a_ctrl_readback: assert property (ctrl_rd |-> rdata_o[5:0] == $past(sh_q))
      else $error("control readback");
   a_unlisted_zero: assert property (rd_i && addr_i == 8'hC9 |=> rdata_o[7:1] == 7'h00)
      else $error("mode spare bits");
   a_unmapped_zero: assert property (rd_i && addr_i < 8'hC8 |=> rdata_o == 8'h00)
      else $error("unmapped read");
   a_rx_from_t1: assert property (t1_ovf_i && !sh_q[5] |=> rx_baud_tick_o)
      else $error("rx tick lost");
   a_rx_idle: assert property (!t1_ovf_i && !sh_q[5] |=> !rx_baud_tick_o)
      else $error("rx tick extra");
   a_tx_from_t1: assert property (t1_ovf_i && !sh_q[4] |=> tx_baud_tick_o)
      else $error("tx tick lost");
   a_baud_same: assert property (sh_q[5] && sh_q[4] |=> rx_baud_tick_o == tx_baud_tick_o)
      else $error("baud ticks differ");
   a_stop_quiet: assert property ((sh_q[5] && !sh_q[2]) [*2] |=> !rx_baud_tick_o)
      else $error("tick while stopped");
   a_irq_ovf: assert property (ctrl_rd ##0 rdata_o[7] |-> timer_irq_req_o)
      else $error("irq missing");
   a_irq_quiet: assert property (ctrl_rd ##0 rdata_o[7:6] == 2'b00 |-> !timer_irq_req_o)
      else $error("irq without flag");
endmodule // tmt_timer_chk
bind tmt_timer tmt_timer_chk u_tmt_timer_chk (.ref_clk_i, .sys_rst_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .bit_wr_i, .bit_sel_i, .bit_val_i, .rdata_o, .t1_ovf_i, .rx_baud_tick_o,
   .tx_baud_tick_o, .timer_irq_req_o);

/* File: tmt_pins_model.sv */
// Purpose: count pin, trigger pin, timer1 ticks
// Assumes: trigger low while fall_req_i
// Notes: free running pattern
`timescale 1ns/1ps
module tmt_pins_model (
   input wire ref_clk_i,
   input wire fall_req_i,
   output wire count_pin_o,
   output wire trigger_pin_o,
   output wire t1_ovf_o
);
   int n = 0;
   always @(posedge ref_clk_i) n <= n + 1;
   assign count_pin_o = (n % 6) < 3;
   assign t1_ovf_o = (n % 7) == 0;
   assign trigger_pin_o = !fall_req_i;
endmodule // tmt_pins_model

/* File: test_tmt_timer.sv */
// Purpose: self-checking bench of tmt_timer
// Assumes: pin model on far side
// Notes: seed 90
`timescale 1ns/1ps
`include "tmt_consts.vh"
module test_tmt_timer;
   logic ref_clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, bit_wr_i = 0, bit_val_i = 0;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, d;
   logic [2:0] bit_sel_i = 0;
   logic [15:0] p, v;
   logic fall_q = 0;
   wire count_pin_i, trigger_pin_i, t1_ovf_i, rx_baud_tick_o, tx_baud_tick_o;
   wire timer_irq_req_o, irq_o;
   int fail_count = 0, tests_run = 0;
   tmt_timer u_tmt_timer (.ref_clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .bit_wr_i, .bit_sel_i, .bit_val_i, .rdata_o, .count_pin_i, .trigger_pin_i, .t1_ovf_i,
      .rx_baud_tick_o, .tx_baud_tick_o, .timer_irq_req_o, .irq_o);
   tmt_pins_model u_tmt_pins_model (.ref_clk_i, .fall_req_i(fall_q),
      .count_pin_o(count_pin_i), .trigger_pin_o(trigger_pin_i), .t1_ovf_o(t1_ovf_i));
   initial forever #25 ref_clk_i = ~ref_clk_i;
   ////////////////////////////////////////
   task chk(input [15:0] seen, exp, input string nm);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [7:0] a, b);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= b;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [7:0] a, output [7:0] q);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
   endtask
   task bw(input [2:0] s, input b);
      @(posedge ref_clk_i);
      bit_sel_i <= s;
      bit_val_i <= b;
      bit_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      bit_wr_i <= 1'b0;
   endtask
   task run(input [7:0] c, input [15:0] st, input int n);
      wr(`TMT_ADDR_CNTL, st[7:0]);
      wr(`TMT_ADDR_CNTH, st[15:8]);
      wr(`TMT_ADDR_CTRL, c);
      repeat (n) @(posedge ref_clk_i);
      bw(3'h2, 1'b0);
      rd(`TMT_ADDR_CNTL, v[7:0]);
      rd(`TMT_ADDR_CNTH, v[15:8]);
      rd(`TMT_ADDR_CTRL, d);
   endtask
   task trig;
      fall_q <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      fall_q <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
   endtask
   function logic [15:0] gap(input [15:0] a, b);
      return b - a;
   endfunction
   task results;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      void'($urandom(90));
      repeat (8) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(`TMT_ADDR_CTRL, d);
      chk(d, 8'h00, "ctrl reset");
      rd(8'h10, d);
      for (int i = 0; i < 6; i++) begin
         bw(i, 1'b1);
         rd(`TMT_ADDR_CTRL, d);
         chk(d[5:0], 6'h01 << i, "bit write");
         bw(i, 1'b0);
      end
      repeat (8) begin
         p = $urandom & 16'h003f;
         wr(`TMT_ADDR_CTRL, p[7:0]);
         rd(`TMT_ADDR_CTRL, d);
         chk(d[5:0], p[5:0], "ctrl bits");
      end
      p = $urandom;
      wr(`TMT_ADDR_CAPL, p[7:0]);
      wr(`TMT_ADDR_CAPH, p[15:8]);
      run(8'h04, 16'hfffd, 10);
      chk(gap(p, v) <= 16'h0010, 1, "reload");
      chk(d[7], 1, "ovf flag");
      chk(timer_irq_req_o, 1, "irq req");
      rd(`TMT_ADDR_CNTL, d);
      chk(d, v[7:0], "held count");
      wr(`TMT_ADDR_IMASK, 8'h01);
      #1 chk(irq_o, 1, "irq on");
      wr(`TMT_ADDR_IMASK, 8'h00);
      #1 chk(irq_o, 0, "irq masked");
      wr(`TMT_ADDR_IMASK, 8'h01);
      wr(`TMT_ADDR_ISTAT, 8'h01);
      #1 chk(irq_o, 0, "irq cleared");
      run(8'h06, 16'h0000, 36);
      chk(v >= 5 && v <= 8, 1, "edges");
      run(8'h35, 16'hfffd, 10);
      chk(d[7], 0, "baud ovf flag");
      chk(gap(p, v) <= 16'h0010, 1, "baud reload");
      wr(`TMT_ADDR_CNTL, 8'h34);
      wr(`TMT_ADDR_CNTH, 8'h12);
      wr(`TMT_ADDR_CTRL, 8'h09);
      trig;
      d = 8'h00;
      for (int k = 0; k < 10 && !d[6]; k++) rd(`TMT_ADDR_CTRL, d);
      chk(d[6], 1, "event flag");
      if (!d[6]) results;
      rd(`TMT_ADDR_CAPL, v[7:0]);
      rd(`TMT_ADDR_CAPH, v[15:8]);
      chk(v, 16'h1234, "capture");
      chk(timer_irq_req_o, 1, "event irq");
      wr(`TMT_ADDR_MODE, 8'h01);
      repeat (2) @(posedge ref_clk_i);
      chk(timer_irq_req_o, 0, "updown irq");
      wr(`TMT_ADDR_MODE, 8'h00);
      wr(`TMT_ADDR_CTRL, 8'h01);
      trig;
      rd(`TMT_ADDR_CTRL, d);
      chk(d[6], 0, "trigger off");
      results;
   end
endmodule // test_tmt_timer
